// ### owd_adc_model.sv
// behavioural converter: registers, channel scan, status-appended reads
`timescale 1ns/1ps
module owd_adc_model #(
   parameter [23:0] FACTORY_GAIN = 24'h50_0000, // arbitrary value
   parameter integer CONV = 100
) (
   input wire clock,
   input wire rst_n,
   input wire sclk,
   input wire mosi,
   input wire cs_n,
   output wire miso
);
   logic [15:0] interface_mode_register_r, gpio_r, setup_r [8], ch_r [16];
   logic [23:0] gain_r [8], code_a [16];
   logic [39:0] sh_r;
   logic [31:0] out_r;
   logic [5:0] ra_r;
   logic [3:0] cur;
   logic rdy_n, rd_frm = 1'b0, dbit = 1'b0;
   int cnt = 0, len = 0, timer, nreads, seen, tail = 16;
   // released line shows the inverse of its last bit; the last data bit
   // stays on the line a few clocks past the final rising edge
   assign miso = cs_n ? ~dbit :
      (rd_frm && (cnt >= 8 || tail < 16)) ? dbit :
      (rdy_n || seen != nreads);
   function logic [3:0] nxt(input logic [3:0] c);
      logic [3:0] k;
      nxt = c;
      for (int i = 16; i >= 1; i--) begin
         k = c + i[3:0];
         if (ch_r[k][15]) nxt = k;
      end
   endfunction
   always @(posedge sclk or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         interface_mode_register_r = 16'h0000;
         gpio_r = 16'h0000;
         nreads = 0;
         cnt = 0;
         foreach (gain_r[i]) gain_r[i] = FACTORY_GAIN;
         foreach (setup_r[i]) setup_r[i] = 16'h1000;
         foreach (ch_r[i]) ch_r[i] = 16'h0001;
         ch_r[0] = 16'h8001;
      end else if (cs_n) cnt = 0;
      else begin
         sh_r = {sh_r[38:0], mosi};
         cnt++;
         if (cnt == 8) begin
            rd_frm = sh_r[6];
            ra_r = sh_r[5:0];
            len = rd_frm ? 40 : (ra_r[5:3] == 3'b111 ? 32 : 24);
         end else if (cnt == len) begin
            cnt = 0;
            if (rd_frm) nreads++;
            else if (ra_r == 6'h02) interface_mode_register_r = sh_r[15:0];
            else if (ra_r == 6'h06) gpio_r = sh_r[15:0];
            else if (ra_r[5:4] == 2'b01) ch_r[ra_r[3:0]] = sh_r[15:0];
            else if (ra_r[5:3] == 3'b100) setup_r[ra_r[2:0]] = sh_r[15:0];
            else if (ra_r[5:3] == 3'b111) gain_r[ra_r[2:0]] = sh_r[23:0];
         end
      end
   end
   // an unread result is replaced, so ready pulses high before the next
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdy_n <= 1'b1;
         timer <= 0;
         seen <= 0;
         tail <= 16;
         cur <= 4'hf;
      end else if (seen != nreads) begin
         seen <= nreads;
         rdy_n <= 1'b1;
         timer <= 0;
         tail <= 0;
      end else if (cnt == 0) begin
         if (tail < 16) tail <= tail + 1;
         timer <= timer + 1;
         if (timer == CONV) begin
            timer <= 0;
            rdy_n <= ~rdy_n;
            if (rdy_n) begin
               cur <= nxt(cur);
               out_r <= {code_a[nxt(cur)], 4'h0, nxt(cur)};
            end
         end
      end
   end
   always @(negedge sclk) begin
      if (!cs_n && rd_frm && cnt >= 8) dbit <= out_r[39 - cnt];
   end
endmodule

// ### owd_code_mem.v
// per-channel store of the latest conversion code, registered read
`timescale 1ns/1ps
module owd_code_mem #(
   parameter AW = 4,
   parameter DW = 24
) (
   input wire clock,
   input wire rst_n,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata_r
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge clock) begin
      if (we)
         mem[waddr] <= wdata;
   end
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         rdata_r <= {DW{1'b0}};
      else
         rdata_r <= mem[raddr];
   end
endmodule

// ### owd_ctrl.v
// open wire host controller: configures the converter and checks pairs
// Functional notes
// R1: converter loads factory current gain into all gain registers at reset.
// R2: host refreshes voltage setup gain after every reset or power-up.
// R3: host may write nominal voltage gain instead of calibrating.
// R4: setups for current inputs have input buffers off.
// R5: setups for voltage inputs have input buffers on.
// R6: host sets open wire enable and paired output enable pin bits.
// R7: host sets the status-append bit of the interface mode register.
// R8: each measured voltage input is converted on two enabled channels.
// R9: single-ended pairs are 15/0, 1/2, 3/4 ... 13/14 only.
// R10: differential pairs are 1/2, 5/6, 9/10, 13/14 only.
// R11: differential channels use input pairs 0/1, 2/3, 4/5, 6/7 only.
// R12: single-ended channels use one input against the common return.
// R13: flag input when absolute code difference of a pair exceeds threshold.
// R14: threshold is 300 mV input referred, bipolar or unipolar code.
// R15: differential use of channels 1 and 2 disables channel 0.
// R16: write interface mode, pin config and setup zero suggested values.
// R17: single-ended pair channels 0x8010, differential pair channels 0x8001.
// R18: converter scans enabled channels ascending, skips disabled, repeats.
// R19: route codes by status channel index; evaluate when both are fresh.
// R20: codes are 24-bit unsigned; difference computed without overflow.
`timescale 1ns/1ps
`include "owd_defs.vh"
module owd_ctrl #(
   parameter [7:0] DIV = 8'h08
) (
   input wire clock,
   input wire rst_n,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata_r,
   output wire sclk,
   output wire mosi,
   output wire cs_n,
   input wire miso
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_CFG = 3'h1;
   localparam [2:0] S_CFGW = 3'h2;
   localparam [2:0] S_WH = 3'h3;
   localparam [2:0] S_WL = 3'h4;
   localparam [2:0] S_RD = 3'h5;
   localparam [2:0] S_RDW = 3'h6;
   localparam [2:0] S_EVAL = 3'h7;
   localparam [2:0] STEP_LAST_SE = 3'h6;
   localparam [2:0] STEP_LAST_DF = 3'h7;

   reg [2:0] state_r;
   reg [2:0] step_r;
   reg diff_mode_r;
   reg unip_r;
   reg cs_hold_r;
   reg spi_start_r;
   reg [5:0] spi_nb_r;
   reg [39:0] spi_tx_r;
   reg [7:0] flags_r;
   reg [7:0] flags_nxt;
   reg [15:0] fresh_r;
   reg [23:0] code_r;
   reg [3:0] ch_r;
   reg [23:0] last_diff_r;
   reg [3:0] last_ch_r;

   wire spi_busy;
   wire spi_done;
   wire [39:0] spi_rx;
   wire rdy_s;
   wire [23:0] peer_code;

   // partner channel of a pair: 15 with 0, then odd with the next even
   function [3:0] partner;
      input [3:0] c;
      begin
         if (c == 4'h0)
            partner = 4'hf;
         else if (c == 4'hf)
            partner = 4'h0;
         else if (c[0])
            partner = c + 4'h1;
         else
            partner = c - 4'h1;
      end
   endfunction

   // pair number 0..7: channel plus one, halved (15 wraps onto 0)
   function [2:0] pair_id;
      input [3:0] c;
      reg [3:0] t;
      begin
         t = c + 4'h1;
         pair_id = t[3:1];
      end
   endfunction

   wire [3:0] rx_ch = spi_rx[3:0];
   wire [23:0] rx_code = spi_rx[31:8];
   wire [2:0] rx_pid = pair_id(rx_ch);
   // in differential mode only the odd-numbered pairs are legal
   wire rx_ok = ~diff_mode_r | rx_pid[0]; // [R10]
   wire store = (state_r == S_RDW) & spi_done & rx_ok; // [R19]
   wire [3:0] ch_peer = partner(ch_r); // [R9]
   wire [2:0] ch_pid = pair_id(ch_r);
   wire peer_fresh = fresh_r[ch_peer]; // [R19]
   // 24-bit unsigned operands: the larger minus the smaller cannot overflow
   wire [23:0] abs_diff = (code_r >= peer_code) ?
      (code_r - peer_code) : (peer_code - code_r); // [R13] [R20]
   wire [23:0] thr = unip_r ? `OWD_THR_UNI : `OWD_THR_BI; // [R14]
   wire ow_hit = (state_r == S_EVAL) & peer_fresh & (abs_diff > thr); // [R13]

   // configuration frame table
   reg [5:0] cfg_addr;
   reg [23:0] cfg_data;
   reg cfg_long;
   reg cfg_last;
   always @* begin
      cfg_addr = `OWD_A_INTERFACE_MODE_REGISTER;
      cfg_data = 24'h00_0000;
      cfg_long = 1'b0;
      cfg_last = 1'b0;
      case (step_r)
         3'h0: begin
            cfg_addr = `OWD_A_INTERFACE_MODE_REGISTER;
            cfg_data = {8'h00, `OWD_V_INTERFACE_MODE_REGISTER}; // [R7] [R16]
         end
         3'h1: begin
            cfg_addr = `OWD_A_GPIO;
            cfg_data = {8'h00, `OWD_V_GPIO}; // [R6] [R16]
         end
         3'h2: begin
            cfg_addr = `OWD_A_SETUP0;
            cfg_data = {8'h00, `OWD_V_SETUP_V}; // [R5] [R16]
         end
         3'h3: begin
            // setup one is kept for current channels
            cfg_addr = `OWD_A_SETUP1;
            cfg_data = {8'h00, `OWD_V_SETUP_I}; // [R4]
         end
         3'h4: begin
            // nominal gain; part-to-part error is accepted over calibrating
            cfg_addr = `OWD_A_SETUP_ZERO_GAIN_COEFF;
            cfg_data = `OWD_V_GAIN_NOM; // [R2] [R3]
            cfg_long = 1'b1;
         end
         3'h5: begin
            cfg_addr = `OWD_A_CH0;
            if (diff_mode_r)
               cfg_data = {8'h00, `OWD_V_CH_OFF}; // [R15]
            else
               cfg_data = {8'h00, `OWD_V_CH_SE}; // [R12] [R17]
         end
         3'h6: begin
            if (diff_mode_r) begin
               cfg_addr = `OWD_A_CH1;
               cfg_data = {8'h00, `OWD_V_CH_DIFF}; // [R11] [R17]
            end else begin
               cfg_addr = `OWD_A_CH15;
               cfg_data = {8'h00, `OWD_V_CH_SE}; // [R8] [R9]
            end
            cfg_last = (step_r == STEP_LAST_SE) & ~diff_mode_r;
         end
         3'h7: begin
            cfg_addr = `OWD_A_CH2;
            cfg_data = {8'h00, `OWD_V_CH_DIFF}; // [R8] [R10]
            cfg_last = (step_r == STEP_LAST_DF);
         end
         default: begin
            cfg_last = 1'b1;
         end
      endcase
   end

   wire wr_ctrl = wr & (addr == `OWD_R_CTRL);
   wire do_start = wr_ctrl & wdata[`OWD_C_START];
   wire do_stop = wr_ctrl & wdata[`OWD_C_STOP];
   wire [7:0] flag_clr = (wr & (addr == `OWD_R_FLAG)) ?
      wdata[7:0] : 8'h00;
   wire [7:0] flag_set = ow_hit ? (8'h01 << ch_pid) : 8'h00;

   // a hit in the clearing cycle survives the clear
   always @* begin
      flags_nxt = (flags_r & ~flag_clr) | flag_set;
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         step_r <= 3'h0;
         diff_mode_r <= 1'b0;
         unip_r <= 1'b0;
         cs_hold_r <= 1'b0;
         spi_start_r <= 1'b0;
         spi_nb_r <= 6'h00;
         spi_tx_r <= 40'h00_0000_0000;
         flags_r <= 8'h00;
         fresh_r <= 16'h0000;
         code_r <= 24'h00_0000;
         ch_r <= 4'h0;
         last_diff_r <= 24'h00_0000;
         last_ch_r <= 4'h0;
      end else begin
         spi_start_r <= 1'b0;
         flags_r <= flags_nxt;
         if (wr_ctrl & (state_r == S_IDLE)) begin
            diff_mode_r <= wdata[`OWD_C_DIFF];
            unip_r <= wdata[`OWD_C_UNIP];
         end
         if (do_stop) begin
            state_r <= S_IDLE;
            cs_hold_r <= 1'b0;
         end else begin
            case (state_r)
               S_IDLE: begin
                  if (do_start & ~spi_busy) begin
                     step_r <= 3'h0;
                     fresh_r <= 16'h0000;
                     cs_hold_r <= 1'b1;
                     state_r <= S_CFG;
                  end
               end
               S_CFG: begin
                  spi_start_r <= 1'b1;
                  if (cfg_long) begin
                     spi_nb_r <= `OWD_NB_W24;
                     spi_tx_r <= {2'b00, cfg_addr, cfg_data, 8'h00};
                  end else begin
                     spi_nb_r <= `OWD_NB_W16;
                     spi_tx_r <= {2'b00, cfg_addr, cfg_data[15:0], 16'h0000};
                  end
                  state_r <= S_CFGW;
               end
               S_CFGW: begin
                  if (spi_done) begin
                     if (cfg_last) begin
                        state_r <= S_WH;
                     end else begin
                        step_r <= step_r + 3'h1;
                        state_r <= S_CFG;
                     end
                  end
               end
               // ready is low only after the line has been seen high again
               S_WH: begin
                  if (rdy_s)
                     state_r <= S_WL;
               end
               S_WL: begin
                  if (!rdy_s)
                     state_r <= S_RD;
               end
               S_RD: begin
                  spi_start_r <= 1'b1;
                  spi_nb_r <= `OWD_NB_RD;
                  spi_tx_r <= {(`OWD_COMM_RD | {2'b00, `OWD_A_DATA}),
                     32'h0000_0000};
                  state_r <= S_RDW;
               end
               S_RDW: begin
                  if (spi_done) begin
                     // the converter's ascending scan is not relied on
                     code_r <= rx_code; // [R18]
                     ch_r <= rx_ch;
                     last_ch_r <= rx_ch;
                     if (rx_ok) begin
                        fresh_r[rx_ch] <= 1'b1; // [R19]
                        state_r <= S_EVAL;
                     end else begin
                        state_r <= S_WH;
                     end
                  end
               end
               S_EVAL: begin
                  if (peer_fresh) begin
                     last_diff_r <= abs_diff; // [R13]
                     fresh_r[ch_r] <= 1'b0;
                     fresh_r[ch_peer] <= 1'b0; // [R19]
                  end
                  state_r <= S_WH;
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   wire cfg_busy = (state_r == S_CFG) | (state_r == S_CFGW);
   wire running = (state_r != S_IDLE) & ~cfg_busy;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `OWD_R_CTRL:
               rdata_r <= {29'h0000_0000, unip_r, diff_mode_r, 1'b0};
            `OWD_R_STAT:
               rdata_r <= {fresh_r, 8'h00, last_ch_r, 1'b0, spi_busy,
                  running, cfg_busy};
            `OWD_R_FLAG:
               rdata_r <= {24'h00_0000, flags_r};
            `OWD_R_DIFF:
               rdata_r <= {8'h00, last_diff_r};
            default:
               rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   owd_spi #(
      .W(40),
      .DIV(DIV)
   ) u_spi (
      .clock(clock),
      .rst_n(rst_n),
      .start(spi_start_r),
      .nbits(spi_nb_r),
      .tx(spi_tx_r),
      .cs_hold(cs_hold_r),
      .miso(miso),
      .sclk_r(sclk),
      .mosi_r(mosi),
      .cs_n_r(cs_n),
      .busy(spi_busy),
      .done_r(spi_done),
      .rx_r(spi_rx),
      .miso_s(rdy_s)
   );

   owd_code_mem #(
      .AW(4),
      .DW(24)
   ) u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .we(store),
      .waddr(rx_ch),
      .wdata(rx_code),
      .raddr(partner(rx_ch)),
      .rdata_r(peer_code)
   );
endmodule

// ### owd_ctrl_checker.sv
// port assertions for the open wire host controller
`timescale 1ns/1ps
module owd_ctrl_checker #(
   parameter [7:0] DIV = 8'h08
) (
   input wire clock,
   input wire rst_n,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata_r,
   input wire sclk,
   input wire mosi,
   input wire cs_n,
   input wire miso
);
   logic [7:0] lo_cnt_r;
   logic [7:0] hi_cnt_r;
   // high count saturates: the link idles high while waiting for ready
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt_r <= 8'h00;
         hi_cnt_r <= 8'h00;
      end else begin
         lo_cnt_r <= sclk ? 8'h00 : lo_cnt_r + 8'h01;
         hi_cnt_r <= !sclk ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hff};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_RD_QUIET: assert property (!rd |=> rdata_r == 32'h0000_0000)
      else $error("read data present without a read");
   AST_UNMAPPED: assert property (rd && addr[1:0] != 2'b00 |=>
      rdata_r == 32'h0000_0000) else $error("unmapped read not zero");
   AST_CTRL_BITS: assert property (rd && addr == 4'h0 |=>
      (rdata_r & 32'hffff_fff9) == 32'h0000_0000)
      else $error("control readback has stray bits");
   AST_FLAG_WIDTH: assert property (rd && addr == 4'h8 |=>
      rdata_r[31:8] == 24'h00_0000) else $error("flag read too wide");
   AST_DIFF_WIDTH: assert property (rd && addr == 4'hc |=>
      rdata_r[31:24] == 8'h00) else $error("difference wider than code");
   AST_START_SEL: assert property (wr && addr == 4'h0 && wdata[0]
      && !wdata[3] && cs_n |-> ##[1:4] !cs_n)
      else $error("start did not select the converter");
   AST_SCLK_LOW: assert property ($rose(sclk) |-> lo_cnt_r == DIV)
      else $error("serial clock low phase wrong");
   AST_SCLK_HIGH: assert property ($fell(sclk) |-> hi_cnt_r >= DIV)
      else $error("serial clock high phase short");
   AST_CS_IDLE: assert property ($fell(cs_n) |-> sclk)
      else $error("select fell with clock low");
   AST_SCLK_SEL: assert property (!sclk |-> !cs_n)
      else $error("clock pulsed while deselected");
   AST_MOSI_SETUP: assert property ($rose(sclk) |-> $stable(mosi))
      else $error("data moved at sampling edge");
   cover property ($fell(cs_n));
   cover property (rd && addr == 4'h8 ##1 rdata_r != 32'h0000_0000);
   cover property (rd && addr == 4'hc ##1 rdata_r != 32'h0000_0000);
endmodule
bind owd_ctrl owd_ctrl_checker #(.DIV(DIV)) chk_u (.clock(clock),
   .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata_r(rdata_r), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso));

// ### owd_ctrl_tb.sv
// self-checking bench for the open wire host controller
`timescale 1ns/1ps
module owd_ctrl_tb;
   logic clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata_r, got;
   wire sclk, mosi, cs_n, miso;
   int fails = 0, checked = 0, cyc = 0, seed = 24297, ca, cb, p, thr, r;
   owd_ctrl dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .sclk(sclk),
      .mosi(mosi), .cs_n(cs_n), .miso(miso));
   owd_adc_model adc_u (.clock(clock), .rst_n(rst_n), .sclk(sclk),
      .mosi(mosi), .cs_n(cs_n), .miso(miso));
   initial begin
      forever #5 clock = ~clock;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         test_done;
      end
   end
   task wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 got = rdata_r;
   endtask
   task wait_reads(input int n);
      while (adc_u.nreads < n) @(posedge clock);
   endtask
   task round(input int a, input int b);
      int base, d;
      adc_u.code_a[ca] = a[23:0];
      adc_u.code_a[cb] = b[23:0];
      base = adc_u.nreads;
      wait_reads(base + 3);
      wreg(4'h8, 32'h0000_00ff);
      wait_reads(base + 5);
      d = a > b ? a - b : b - a;
      rreg(4'hc);
      chk(got, d);
      rreg(4'h8);
      chk(got, 32'(d > thr) << p);
   endtask
   initial begin
      for (int m = 0; m < 3; m++) begin
         rst_n <= 1'b0;
         repeat (3) @(posedge clock);
         rst_n <= 1'b1;
         ca = m ? 1 : 0;
         cb = m ? 2 : 15;
         p = m ? 1 : 0;
         thr = m == 2 ? 200000 : 100000;
         if (m == 0) begin
            wreg(4'h2, 32'hffff_ffff);
            rreg(4'h2);
            chk(got, 32'h0000_0000);
            rreg(4'h8);
            chk(got, 32'h0000_0000);
         end
         wreg(4'h0, m == 0 ? 32'h0000_0001 : m == 1 ? 32'h3 : 32'h7);
         rreg(4'h0);
         chk(got, m == 0 ? 32'h0 : m == 1 ? 32'h2 : 32'h6);
         wait_reads(1);
         chk(adc_u.interface_mode_register_r, 16'h0040);
         chk(adc_u.gpio_r, 16'h3800);
         chk(adc_u.setup_r[0], 16'h1300);
         chk(adc_u.setup_r[1], 16'h1000);
         chk(adc_u.gain_r[0], 24'h55_567c);
         chk(adc_u.gain_r[1], adc_u.FACTORY_GAIN);
         chk(adc_u.ch_r[0], m ? 16'h0000 : 16'h8010);
         chk(adc_u.ch_r[ca], m ? 16'h8001 : 16'h8010);
         chk(adc_u.ch_r[cb], m ? 16'h8001 : 16'h8010);
         rreg(4'h4);
         chk(got & 32'h0000_0003, 32'h0000_0002);
         round(9129327, 9360856);
         round(8725210, 8725200);
         r = 32'h0040_0000 + ($random(seed) & 32'h000f_ffff);
         round(r, r + thr);
         round(r + thr + 1, r);
         wreg(4'h0, 32'h0000_0008);
         repeat (720) @(posedge clock);
         chk(cs_n, 1'b1);
         rreg(4'h4);
         chk(got & 32'h0000_0007, 32'h0000_0000);
      end
      test_done;
   end
endmodule

// ### owd_defs.vh
// shared constants for the open wire host controller
`ifndef OWD_DEFS_VH
`define OWD_DEFS_VH
// converter register addresses (6-bit)
`define OWD_A_INTERFACE_MODE_REGISTER 6'h02
`define OWD_A_DATA 6'h04
`define OWD_A_GPIO 6'h06
`define OWD_A_CH0 6'h10
`define OWD_A_CH1 6'h11
`define OWD_A_CH2 6'h12
`define OWD_A_CH15 6'h1f
`define OWD_A_SETUP0 6'h20
`define OWD_A_SETUP1 6'h21
`define OWD_A_SETUP_ZERO_GAIN_COEFF 6'h38
// communications byte read flag
`define OWD_COMM_RD 8'h40
// configuration values written to the converter
`define OWD_V_INTERFACE_MODE_REGISTER 16'h0040
`define OWD_V_GPIO 16'h3800
`define OWD_V_SETUP_V 16'h1300
`define OWD_V_SETUP_I 16'h1000
`define OWD_V_GAIN_NOM 24'h55_567c
`define OWD_V_CH_SE 16'h8010
`define OWD_V_CH_DIFF 16'h8001
`define OWD_V_CH_OFF 16'h0000
// open wire thresholds in output codes
`define OWD_THR_BI 24'h01_86a0
`define OWD_THR_UNI 24'h03_0d40
// frame lengths in bits
`define OWD_NB_W16 6'h18
`define OWD_NB_W24 6'h20
`define OWD_NB_RD 6'h28
// software register byte offsets
`define OWD_R_CTRL 4'h0
`define OWD_R_STAT 4'h4
`define OWD_R_FLAG 4'h8
`define OWD_R_DIFF 4'hc
// control register bits
`define OWD_C_START 0
`define OWD_C_DIFF 1
`define OWD_C_UNIP 2
`define OWD_C_STOP 3
`endif

// ### owd_spi.v
// serial master: mode 3 shifter with divided clock and synchronised input
`timescale 1ns/1ps
module owd_spi #(
   parameter W = 40,
   parameter [7:0] DIV = 8'h08
) (
   input wire clock,
   input wire rst_n,
   input wire start,
   input wire [5:0] nbits,
   input wire [W-1:0] tx,
   input wire cs_hold,
   input wire miso,
   output reg sclk_r,
   output reg mosi_r,
   output reg cs_n_r,
   output wire busy,
   output reg done_r,
   output reg [W-1:0] rx_r,
   output wire miso_s
);
   localparam [7:0] DIV_M1 = DIV - 8'h01;
   reg [W-1:0] sh_r;
   reg [7:0] cnt_r;
   reg [5:0] bit_r;
   reg phase_r;
   reg smp_r;
   reg busy_r;
   reg m1_r;
   reg m2_r;
   assign busy = busy_r;
   assign miso_s = m2_r;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= {W{1'b0}};
         rx_r <= {W{1'b0}};
         cnt_r <= 8'h00;
         bit_r <= 6'h00;
         phase_r <= 1'b0;
         smp_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         sclk_r <= 1'b1;
         mosi_r <= 1'b0;
         cs_n_r <= 1'b1;
         m1_r <= 1'b1;
         m2_r <= 1'b1;
      end else begin
         m1_r <= miso;
         m2_r <= m1_r;
         // a frame cut short by stop keeps select low until it has clocked out
         cs_n_r <= ~(cs_hold | busy_r);
         done_r <= 1'b0;
         if (!busy_r) begin
            if (start) begin
               busy_r <= 1'b1;
               sh_r <= tx;
               bit_r <= nbits;
               cnt_r <= 8'h00;
               phase_r <= 1'b0;
               smp_r <= 1'b0;
            end
         end else if (cnt_r != DIV_M1) begin
            cnt_r <= cnt_r + 8'h01;
         end else begin
            cnt_r <= 8'h00;
            if (!phase_r) begin
               // sample late in the high phase: the synchroniser adds delay
               if (smp_r)
                  rx_r <= {rx_r[W-2:0], m2_r};
               if (bit_r == 6'h00) begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end else begin
                  sclk_r <= 1'b0;
                  mosi_r <= sh_r[W-1];
                  sh_r <= {sh_r[W-2:0], 1'b0};
                  phase_r <= 1'b1;
               end
            end else begin
               sclk_r <= 1'b1;
               bit_r <= bit_r - 6'h01;
               smp_r <= 1'b1;
               phase_r <= 1'b0;
            end
         end
      end
   end
endmodule
